// file: hw/bcc_params.svh
// Offsets, field positions, reset values and codes for the bridge capability block.
// Assumes byte addresses on the configuration port, one aligned 32-bit word per register.
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define BCC_OFF_DS_SPLIT 8'h8c
`define BCC_OFF_PM_CAP 8'h90
`define BCC_OFF_PM_CSR 8'h94
`define BCC_OFF_W0_BASE 8'h98
`define BCC_OFF_W0_SETUP 8'h9c
`define BCC_OFF_SLOT 8'ha0
`define BCC_OFF_SEC_CLK 8'ha4
`define BCC_OFF_W1_BASE 8'ha8
`define BCC_OFF_W1_SETUP 8'hac

////////////////////////////////////////////////////////////////////////////////
// Split transaction
`define BCC_SPLIT_CAP 16'h0010
`define BCC_SPLIT_LIMIT_RST 16'h0010
`define BCC_SPLIT_UNLIMITED 16'hffff

////////////////////////////////////////////////////////////////////////////////
// Power management capability
`define BCC_PM_CAP_ID 8'h01
`define BCC_PM_NEXT 8'ha8
`define BCC_PM_VERSION 3'h3
`define BCC_PM_AUX_RST 3'h1
`define BCC_PM_EVT_SUPPORT 5'h19
`define BCC_PM_EN_BIT 8
`define BCC_PM_STS_BIT 15

////////////////////////////////////////////////////////////////////////////////
// Translation windows
`define BCC_W0_LSB 12
`define BCC_W1_LSB 6
`define BCC_W0_MASK_RST 19'h7ffff
`define BCC_W0_MASK_FULL 19'h7ffff
`define BCC_W1_MASK_RST 25'h0000000
`define BCC_W1_MEM_ZERO 6
`define BCC_EN_BIT 31

////////////////////////////////////////////////////////////////////////////////
// Slot numbering and secondary clocks
`define BCC_SI_CAP_ID 8'h04
`define BCC_SI_NEXT 8'hb0
`define BCC_CLK_STOP_CODE 2'h3
`define BCC_CLK_PAIRS 4
`define BCC_CLK_SINGLE_LSB 8
`define BCC_CLK_STS_BIT 13
`define BCC_CLK_RUN_EN_BIT 14
`define BCC_CLK_MODE_BIT 15

`endif

// file: hw/bcc_pkg.sv
// Types shared by the bridge capability block.
// Assumes bcc_params.svh supplies the numeric constants.
package bcc_pkg;

   typedef enum logic [1:0] {
      BCC_D0 = 2'b00,
      BCC_D1 = 2'b01,
      BCC_D2 = 2'b10,
      BCC_D3HOT = 2'b11
   } bcc_pstate_e;

   typedef logic [31:0] bcc_word_t;

endpackage

// file: hw/bcc_regs.sv
// Configuration register group: split limit, power management, translation windows,
// slot numbering and secondary clock control.
// Assumes a same-clock configuration port (read data one cycle after the read strobe),
// a same-clock setup-load port for the strap-written window fields, and event inputs
// from logic on clk; only the bridge mode strap comes from a pin.
`timescale 1ns/1ps
`include "bcc_params.svh"

module bcc_regs #(
   parameter int NUM_SEC_CLK = 7
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output bcc_pkg::bcc_word_t reg_rdata,
   input wire logic setup_wr,
   input wire logic setup_sel,
   input wire logic [31:0] setup_wdata,
   input wire logic forward_mode_pin,
   input wire logic power_event,
   input wire logic sec_bus_idle,
   input wire logic primary_req_pending,
   output logic [15:0] split_limit,
   output logic split_forward_all,
   output logic [1:0] power_state,
   output logic internal_reset,
   output logic power_event_pin_o,
   output logic power_event_pin_oe,
   output logic [31:12] win0_xlat_base,
   output logic [30:12] win0_size_mask,
   output logic win0_enable,
   output logic [31:6] win1_xlat_base,
   output logic [30:6] win1_size_mask,
   output logic win1_enable,
   output logic [NUM_SEC_CLK-1:0] secondary_clock_output_en,
   output logic sec_clock_stopped
);
   import bcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Only the all-ones code stops a paired clock; the other three run it
   function automatic logic pair_stops(input logic [1:0] code);
      pair_stops = (code == `BCC_CLK_STOP_CODE);
   endfunction

   wire wr_split = reg_wr && hit(reg_addr, `BCC_OFF_DS_SPLIT);
   wire wr_pm = reg_wr && hit(reg_addr, `BCC_OFF_PM_CSR);
   wire wr_w0 = reg_wr && hit(reg_addr, `BCC_OFF_W0_BASE);
   wire wr_slot = reg_wr && hit(reg_addr, `BCC_OFF_SLOT);
   wire wr_clk = reg_wr && hit(reg_addr, `BCC_OFF_SEC_CLK);
   wire wr_w1 = reg_wr && hit(reg_addr, `BCC_OFF_W1_BASE);
   wire ld_w0 = setup_wr && !setup_sel;
   wire ld_w1 = setup_wr && setup_sel;

   ////////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser; first stage feeds only the second
   // Strap may move at any time; only the settled level gates clock 6
   logic fwd_meta;
   logic fwd_mode;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fwd_meta <= 1'b0;
         fwd_mode <= 1'b0;
      end else begin
         fwd_meta <= forward_mode_pin;
         fwd_mode <= fwd_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Split commitment limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         split_limit <= `BCC_SPLIT_LIMIT_RST;
      end else if (wr_split) begin
         split_limit <= reg_wdata[31:16];
      end
   end

   // Any limit is accepted; all-ones lifts the buffer check
   assign split_forward_all = (split_limit == `BCC_SPLIT_UNLIMITED);

   ////////////////////////////////////////////////////////////////////////////////
   // Power state and power event
   logic pme_en;
   logic pme_sts;
   logic [2:0] aux_current;
   bcc_pstate_e ps_req;

   assign ps_req = bcc_pstate_e'(reg_wdata[1:0]);
   // D1 and D2 are not offered, so only D0 and D3hot are accepted
   wire ps_legal = (ps_req == BCC_D0) || (ps_req == BCC_D3HOT);
   // Registers here keep their values; the pulse resets the core behind
   wire ps_wake = wr_pm && ps_legal && (ps_req == BCC_D0) && (power_state == BCC_D3HOT);
   wire pme_clr = wr_pm && reg_wdata[`BCC_PM_STS_BIT];
   wire wd_pme_en = reg_wdata[`BCC_PM_EN_BIT];
   wire next_pme_sts = power_event ? 1'b1 : (pme_clr ? 1'b0 : pme_sts);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_state <= BCC_D0;
         internal_reset <= 1'b0;
         aux_current <= `BCC_PM_AUX_RST;
      end else begin
         if (wr_pm && ps_legal) begin
            power_state <= ps_req;
         end
         // Secondary bus reset pin is left alone on wake
         internal_reset <= ps_wake;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pme_en <= 1'b0;
         pme_sts <= 1'b0;
         power_event_pin_oe <= 1'b0;
      end else begin
         if (wr_pm) begin
            pme_en <= wd_pme_en;
         end
         pme_sts <= next_pme_sts;
         power_event_pin_oe <= pme_en && pme_sts;
      end
   end

   // Open-drain: only ever pulls low
   assign power_event_pin_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Window 0
   logic [2:1] w0_atype;
   logic w0_pref;
   // A cleared enable in the load word leaves the smallest 4 KB window
   wire w0_en_cleared = !setup_wdata[`BCC_EN_BIT];
   wire [30:12] w0_mask_in = w0_en_cleared ? `BCC_W0_MASK_FULL : setup_wdata[30:12];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win0_size_mask <= `BCC_W0_MASK_RST;
         win0_enable <= 1'b1;
         w0_atype <= 2'h0;
         w0_pref <= 1'b0;
      end else if (ld_w0) begin
         win0_size_mask <= w0_mask_in;
         w0_atype <= setup_wdata[2:1];
         w0_pref <= setup_wdata[3];
         // A zero written to the enable is turned back into one
         win0_enable <= 1'b1;
      end
   end

   wire [31:12] w0_wmask = {win0_enable, win0_size_mask};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win0_xlat_base <= '0;
      end else if (wr_w0) begin
         win0_xlat_base <= (reg_wdata[31:12] & w0_wmask) |
                           (win0_xlat_base & ~w0_wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Window 1
   logic [2:1] w1_atype;
   logic w1_pref;
   // Always memory space, so the low six mask bits are held at zero
   wire [30:6] w1_mask_in = {setup_wdata[30:12], 6'h00};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win1_size_mask <= `BCC_W1_MASK_RST;
         win1_enable <= 1'b0;
         w1_atype <= 2'h0;
         w1_pref <= 1'b0;
      end else if (ld_w1) begin
         win1_size_mask <= w1_mask_in;
         w1_atype <= setup_wdata[2:1];
         w1_pref <= setup_wdata[3];
         // Window 1 enable follows the load word; reset leaves it off
         win1_enable <= setup_wdata[`BCC_EN_BIT];
      end
   end

   wire [31:6] w1_wmask = {win1_enable, win1_size_mask};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         win1_xlat_base <= '0;
      end else if (wr_w1) begin
         win1_xlat_base <= (reg_wdata[31:6] & w1_wmask) |
                           (win1_xlat_base & ~w1_wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Slot and chassis numbering
   logic [4:0] slot_num;
   logic first_in_chassis;
   logic [7:0] chassis_num;
   // Plain storage for software; only the read mux reads it back

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_num <= '0;
         first_in_chassis <= 1'b0;
         chassis_num <= '0;
      end else if (wr_slot) begin
         slot_num <= reg_wdata[20:16];
         first_in_chassis <= reg_wdata[21];
         chassis_num <= reg_wdata[31:24];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Secondary clock control
   logic [10:0] clk_ctl;
   logic clkrun_en;
   logic clkrun_mode;
   logic [NUM_SEC_CLK-1:0] clk_stop;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_ctl <= '0;
         clkrun_en <= 1'b0;
         clkrun_mode <= 1'b0;
      end else if (wr_clk) begin
         clk_ctl <= reg_wdata[10:0];
         clkrun_en <= reg_wdata[`BCC_CLK_RUN_EN_BIT];
         clkrun_mode <= reg_wdata[`BCC_CLK_MODE_BIT];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SEC_CLK; gi++) begin : g_clk
         if (gi < `BCC_CLK_PAIRS) begin : g_pair
            assign clk_stop[gi] = pair_stops(clk_ctl[2*gi+1:2*gi]);
         end else if (gi == NUM_SEC_CLK - 1) begin : g_self
            // The bridge's own clock control bit only gates it in forward mode
            assign clk_stop[gi] = clk_ctl[`BCC_CLK_SINGLE_LSB + gi - `BCC_CLK_PAIRS]
                                  && fwd_mode;
         end else begin : g_single
            assign clk_stop[gi] = clk_ctl[`BCC_CLK_SINGLE_LSB + gi - `BCC_CLK_PAIRS];
         end
      end
   endgenerate

   wire idle_stop = sec_bus_idle && !primary_req_pending;
   wire d3_stop = (power_state == BCC_D3HOT);
   wire stop_cond = clkrun_mode ? idle_stop : d3_stop;
   wire next_stopped = clkrun_en && stop_cond;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_clock_stopped <= 1'b0;
         secondary_clock_output_en <= '0;
      end else begin
         sec_clock_stopped <= next_stopped;
         secondary_clock_output_en <= ~clk_stop & {NUM_SEC_CLK{!next_stopped}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   wire [31:0] rd_split = {split_limit, `BCC_SPLIT_CAP};
   // Clock, reserved, init, D1 and D2 bits are zero
   wire [31:0] rd_pmcap = {`BCC_PM_EVT_SUPPORT,
                           1'b0,
                           1'b0,
                           aux_current,
                           1'b0,
                           1'b0,
                           1'b0,
                           `BCC_PM_VERSION,
                           `BCC_PM_NEXT,
                           `BCC_PM_CAP_ID};
   wire [31:0] rd_pmcsr = {16'h0000,
                           pme_sts,
                           6'h00,
                           pme_en,
                           6'h00,
                           power_state};
   wire [31:0] rd_w0b = {win0_xlat_base, 12'h000};
   wire [31:0] rd_w0s = {win0_enable,
                         win0_size_mask,
                         8'h00,
                         w0_pref,
                         w0_atype,
                         1'b0};
   wire [31:0] rd_slot = {chassis_num,
                          2'h0,
                          first_in_chassis,
                          slot_num,
                          `BCC_SI_NEXT,
                          `BCC_SI_CAP_ID};
   wire [31:0] rd_clk = {16'h0000,
                         clkrun_mode,
                         clkrun_en,
                         sec_clock_stopped,
                         2'h0,
                         clk_ctl};
   wire [31:0] rd_w1b = {win1_xlat_base, 6'h00};
   wire [31:0] rd_w1s = {win1_enable,
                         win1_size_mask,
                         2'h0,
                         w1_pref,
                         w1_atype,
                         1'b0};

   logic [31:0] rd_mux;

   always_comb begin
      unique case (reg_addr)
         `BCC_OFF_DS_SPLIT: rd_mux = rd_split;
         `BCC_OFF_PM_CAP: rd_mux = rd_pmcap;
         `BCC_OFF_PM_CSR: rd_mux = rd_pmcsr;
         `BCC_OFF_W0_BASE: rd_mux = rd_w0b;
         `BCC_OFF_W0_SETUP: rd_mux = rd_w0s;
         `BCC_OFF_SLOT: rd_mux = rd_slot;
         `BCC_OFF_SEC_CLK: rd_mux = rd_clk;
         `BCC_OFF_W1_BASE: rd_mux = rd_w1b;
         `BCC_OFF_W1_SETUP: rd_mux = rd_w1s;
         // Unmapped offsets read zero, so a probe finds nothing there
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

endmodule

// file: verification/bcc_far_side.sv
// Far-side model: power event source, secondary bus idle and primary request levels.
// Assumes the bench drives ev_cmd and req_cmd off the clock edge; event pin has a pull-up.
`timescale 1ns/1ps
module bcc_far_side (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ev_cmd,
   input wire logic [1:0] req_cmd,
   input wire logic power_event_pin_o,
   input wire logic power_event_pin_oe,
   output logic power_event,
   output logic sec_bus_idle,
   output logic primary_req_pending,
   output logic power_event_pin_n
);
   // Released pin reads the pull-up, never the last driven level
   assign power_event_pin_n = power_event_pin_oe ? power_event_pin_o : 1'b1;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_event <= 1'b0;
         sec_bus_idle <= 1'b1;
         primary_req_pending <= 1'b0;
      end else begin
         power_event <= ev_cmd;
         sec_bus_idle <= !req_cmd[0];
         primary_req_pending <= req_cmd[1];
      end
   end
endmodule

// file: verification/bcc_regs_properties.sv
// Port-level checks for bcc_regs.
// Assumes one clk domain and asynchronous active-low rstn.
`timescale 1ns/1ps
module bcc_regs_properties #(
   parameter int NUM_SEC_CLK = 7
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire bcc_pkg::bcc_word_t reg_rdata,
   input wire logic power_event,
   input wire logic [15:0] split_limit,
   input wire logic split_forward_all,
   input wire logic [1:0] power_state,
   input wire logic internal_reset,
   input wire logic power_event_pin_oe,
   input wire logic win0_enable,
   input wire logic [NUM_SEC_CLK-1:0] secondary_clock_output_en,
   input wire logic sec_clock_stopped
);
   // Delayed write data, so later checks see the word that caused them
   logic [31:0] wd_1, wd_2;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wd_1 <= 32'h0;
         wd_2 <= 32'h0;
      end else begin
         wd_1 <= reg_wdata;
         wd_2 <= wd_1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   property p_fwd;
      split_forward_all == (split_limit == 16'hffff);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward-all flag wrong");
   property p_lim;
      reg_wr && reg_addr == 8'h8c |=> split_limit == wd_1[31:16];
   endproperty
   a_lim: assert property (p_lim) else $error("limit not written");
   property p_ign;
      reg_wr && reg_addr == 8'h94 && reg_wdata[1] != reg_wdata[0] |=> $stable(power_state);
   endproperty
   a_ign: assert property (p_ign) else $error("bad state taken");
   property p_wake;
      reg_wr && reg_addr == 8'h94 && reg_wdata[1:0] == 2'h0 && power_state == 2'h3
         |=> internal_reset ##1 !internal_reset;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse");
   property p_clr;
      reg_wr && reg_addr == 8'h94 && reg_wdata[15] && !power_event |-> ##2 !power_event_pin_oe;
   endproperty
   a_clr: assert property (p_clr) else $error("event pin held");
   property p_en0;
      win0_enable;
   endproperty
   a_en0: assert property (p_en0) else $error("window 0 disabled");
   property p_pm;
      reg_rd && reg_addr == 8'h90 |=> reg_rdata == 32'hc843a801;
   endproperty
   a_pm: assert property (p_pm) else $error("power capability word wrong");
   property p_sid;
      reg_rd && reg_addr == 8'ha0 |=> reg_rdata[15:0] == 16'hb004;
   endproperty
   a_sid: assert property (p_sid) else $error("slot capability header wrong");
   property p_cs;
      reg_wr && reg_addr == 8'ha4 && !reg_wdata[14] |-> ##2 secondary_clock_output_en[5:0] ==
         {~wd_2[9:8], wd_2[7:6] != 2'h3, wd_2[5:4] != 2'h3, wd_2[3:2] != 2'h3, wd_2[1:0] != 2'h3};
   endproperty
   a_cs: assert property (p_cs) else $error("clock enables wrong");
   property p_stop;
      reg_wr && reg_addr == 8'ha4 && reg_wdata[14] && !reg_wdata[15]
         |-> ##2 sec_clock_stopped == ($past(power_state) == 2'h3);
   endproperty
   a_stop: assert property (p_stop) else $error("clock stop wrong");
   c_wake: cover property (internal_reset);
   c_evt: cover property (power_event_pin_oe);
   c_stop: cover property (sec_clock_stopped);
endmodule

bind bcc_regs bcc_regs_properties #(.NUM_SEC_CLK(NUM_SEC_CLK)) i_bcc_regs_properties (.*);

// file: verification/bcc_regs_tb.sv
// Self-checking bench for bcc_regs beside the far-side model.
// Assumes 100 MHz clk and read data one cycle after the read strobe.
`timescale 1ns/1ps
module bcc_regs_tb;
   import bcc_pkg::*;
   logic clk, rstn, reg_wr, reg_rd, setup_wr, setup_sel, forward_mode_pin;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, setup_wdata;
   logic power_event, sec_bus_idle, primary_req_pending, ev_cmd, power_event_pin_n;
   logic [1:0] req_cmd, power_state;
   bcc_word_t reg_rdata;
   logic [15:0] split_limit;
   logic split_forward_all, internal_reset, power_event_pin_o, power_event_pin_oe;
   logic win0_enable, win1_enable, sec_clock_stopped;
   logic [31:12] win0_xlat_base;
   logic [30:12] win0_size_mask;
   logic [31:6] win1_xlat_base;
   logic [30:6] win1_size_mask;
   logic [6:0] secondary_clock_output_en;
   int fail_count, num_checks;
   // Last word read is non-zero, so the idle check after it can fail
   localparam logic [7:0] RA [10] = '{8'h80, 8'h8c, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4,
      8'ha8, 8'hac, 8'h90};
   localparam logic [31:0] RE [10] = '{32'h0, 32'h00100010, 32'h0, 32'h0,
      32'hfffff000, 32'h0000b004, 32'h0, 32'h0, 32'h0, 32'hc843a801};

   bcc_regs i_bcc_regs (.*);
   bcc_far_side i_bcc_far_side (.*);
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("word %h", a), e & m, reg_rdata & m);
   endtask
   task automatic setup(input logic s, input logic [31:0] d);
      setup_sel <= s;
      setup_wdata <= d;
      setup_wr <= 1'b1;
      cyc(1);
      setup_wr <= 1'b0;
   endtask
   task automatic pulse_event;
      ev_cmd <= 1'b1;
      cyc(1);
      ev_cmd <= 1'b0;
      cyc(3);
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 10; i++) rd(RA[i], 32'hffffffff, RE[i]);
      cyc(1);
      chk("rdata idle", 32'h0, reg_rdata);
      chk("clock en", 32'h7f, {25'h0, secondary_clock_output_en});
      $display("test reset done");
   endtask
   task automatic t_split;
      wr(8'h8c, 32'hffff1234);
      chk("limit", 32'hffff, {16'h0, split_limit});
      chk("fwd all", 32'h1, {31'h0, split_forward_all});
      rd(8'h8c, 32'hffffffff, 32'hffff0010);
      wr(8'h8c, 32'hfffe0000);
      chk("fwd all", 32'h0, {31'h0, split_forward_all});
      wr(8'ha0, 32'hffffffff);
      rd(8'ha0, 32'hffffffff, 32'hff3fb004);
      $display("test split done");
   endtask
   task automatic t_pm;
      wr(8'h94, 32'h3);
      wr(8'h94, 32'h1);
      wr(8'h94, 32'h2);
      chk("state", 32'h3, {30'h0, power_state});
      wr(8'h94, 32'h0);
      chk("wake", 32'h1, {31'h0, internal_reset});
      cyc(1);
      chk("wake end", 32'h0, {31'h0, internal_reset});
      wr(8'h94, 32'h100);
      pulse_event();
      chk("pin", 32'h0, {31'h0, power_event_pin_n});
      rd(8'h94, 32'hffffffff, 32'h8100);
      wr(8'h94, 32'h8100);
      cyc(1);
      chk("pin", 32'h1, {31'h0, power_event_pin_n});
      wr(8'h94, 32'h0);
      pulse_event();
      chk("gated", 32'h0, {31'h0, power_event_pin_oe});
      rd(8'h94, 32'hffffffff, 32'h8000);
      wr(8'h94, 32'h8000);
      $display("test power done");
   endtask
   task automatic t_win;
      setup(1'b0, 32'h8000f008);
      wr(8'h98, 32'hffffffff);
      chk("w0 base", 32'h8000f, {12'h0, win0_xlat_base});
      chk("w0 mask", 32'hf, {13'h0, win0_size_mask});
      rd(8'h98, 32'hffffffff, 32'h8000f000);
      rd(8'h9c, 32'hffffffff, 32'h8000f008);
      setup(1'b0, 32'h0);
      chk("w0 en", 32'h1, {31'h0, win0_enable});
      chk("w0 mask", 32'h7ffff, {13'h0, win0_size_mask});
      rd(8'h9c, 32'hfffff000, 32'hfffff000);
      setup(1'b1, 32'h8000ffc2);
      wr(8'ha8, 32'hffffffff);
      chk("w1 mask", 32'h3c0, {7'h0, win1_size_mask});
      chk("w1 base", 32'h20003c0, {6'h0, win1_xlat_base});
      chk("w1 en", 32'h1, {31'h0, win1_enable});
      rd(8'hac, 32'hffffffff, 32'h8000f002);
      rd(8'ha8, 32'hffffffff, 32'h8000f000);
      $display("test window done");
   endtask
   task automatic t_clk;
      for (int c = 0; c < 4; c++) begin
         wr(8'ha4, 32'h55 * c);
         cyc(1);
         chk("clk 0-3", (c == 3) ? 32'h0 : 32'hf, {28'h0, secondary_clock_output_en[3:0]});
      end
      wr(8'ha4, 32'h700);
      cyc(1);
      chk("clk 4-6", 32'h0, {29'h0, secondary_clock_output_en[6:4]});
      forward_mode_pin <= 1'b0;
      cyc(3);
      chk("clk 4-6", 32'h4, {29'h0, secondary_clock_output_en[6:4]});
      wr(8'h94, 32'h3);
      wr(8'ha4, 32'h4000);
      cyc(1);
      chk("stopped", 32'h1, {31'h0, sec_clock_stopped});
      chk("clk all", 32'h0, {25'h0, secondary_clock_output_en});
      rd(8'ha4, 32'h6000, 32'h6000);
      wr(8'h94, 32'h0);
      cyc(1);
      chk("stopped", 32'h0, {31'h0, sec_clock_stopped});
      wr(8'ha4, 32'hc000);
      cyc(1);
      chk("idle stop", 32'h1, {31'h0, sec_clock_stopped});
      req_cmd <= 2'h2;
      cyc(2);
      chk("pending", 32'h0, {31'h0, sec_clock_stopped});
      req_cmd <= 2'h0;
      cyc(2);
      chk("idle again", 32'h1, {31'h0, sec_clock_stopped});
      req_cmd <= 2'h1;
      cyc(2);
      chk("bus busy", 32'h0, {31'h0, sec_clock_stopped});
      $display("test clock done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rstn, reg_wr, reg_rd, setup_wr, setup_sel, ev_cmd} = 6'h0;
      {reg_addr, reg_wdata, setup_wdata} = 72'h0;
      forward_mode_pin = 1'b1;
      req_cmd = 2'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      cyc(1);
      t_reset();
      t_split();
      t_pm();
      t_win();
      t_clk();
      test_done();
   end
   // Whole run is under a hundred cycles; 10000 cycles means a hang
   initial begin
      #100000;
      fail_count++;
      $display("watchdog expired");
      test_done();
   end
endmodule
